// *** design/jog_search_ctrl.v ***
// keypad jog and index search utility control
`timescale 1ns/1ns
`include "jog_search_map.vh"
module jog_search_ctrl #(
  parameter HOLD_CYCLES  = `HOLD_TIME_MS * `CLK_FREQ_KHZ,
  parameter BLINK_CYCLES = `BLINK_TIME_MS * `CLK_FREQ_KHZ
) (
  input  wire                 i_clk,
  input  wire                 i_rst_n,
  input  wire                 i_display_set_key,
  input  wire                 i_enter_key,
  input  wire                 i_shift_key,
  input  wire                 i_up_key,
  input  wire                 i_down_key,
  input  wire                 i_servo_enable_key,
  input  wire                 i_servo_ready,
  input  wire                 i_ext_servo_on,
  input  wire                 i_index_pulse,
  input  wire                 i_forward_overtravel_inhibit,
  input  wire                 i_reverse_overtravel_inhibit,
  input  wire [`MAP_W-1:0]    i_servo_enable_input_mapping,
  input  wire [`SPEED_W-1:0]  i_jog_speed_setting,
  input  wire                 i_direction_select,
  output reg                  o_servo_enable,
  output reg                  o_run,
  output reg                  o_dir_forward,
  output reg  [`SPEED_W-1:0]  o_speed_ref,
  output reg                  o_hold_at_index,
  output reg                  o_forward_stop,
  output reg                  o_reverse_stop,
  output reg  [`MODE_W-1:0]   o_display_mode,
  output reg  [`FUNC_W-1:0]   o_function_number,
  output reg                  o_digit_blink,
  output reg                  o_display_blink,
  output reg                  o_start_refused
);

  localparam [`MODE_W-1:0] ST_STATUS = `MODE_STATUS;
  localparam [`MODE_W-1:0] ST_SELECT = `MODE_SELECT;
  localparam [`MODE_W-1:0] ST_JOG    = `MODE_JOG;
  localparam [`MODE_W-1:0] ST_SEARCH = `MODE_SEARCH;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // bit order: set, enter, shift, up, down, svkey, ready, ext, index, fot, rot
  wire [10:0] pins_raw;
  reg  [10:0] pins_meta_reg;
  reg  [10:0] pins_sync_reg;
  reg  [10:0] pins_last_reg;

  assign pins_raw = {i_display_set_key, i_enter_key, i_shift_key, i_up_key,
                     i_down_key, i_servo_enable_key, i_servo_ready,
                     i_ext_servo_on, i_index_pulse,
                     i_forward_overtravel_inhibit, i_reverse_overtravel_inhibit};

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_meta_reg <= 11'h000;
      pins_sync_reg <= 11'h000;
      pins_last_reg <= 11'h000;
    end else begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_last_reg <= pins_sync_reg;
    end
  end

  wire [10:0] press = pins_sync_reg & ~pins_last_reg;

  wire set_press   = press[10];
  wire enter_press = press[9];
  wire shift_lvl   = pins_sync_reg[8];
  wire up_lvl      = pins_sync_reg[7];
  wire down_lvl    = pins_sync_reg[6];
  wire up_press    = press[7];
  wire down_press  = press[6];
  wire svkey_press = press[5];
  wire ready       = pins_sync_reg[4];
  wire ext_on      = pins_sync_reg[3];
  wire index_edge  = press[2];
  wire fot         = pins_sync_reg[1];
  wire rot         = pins_sync_reg[0];

  // ----------------------------------------
  // shift hold and blink timing
  // ----------------------------------------
  wire shift_held;

  key_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_shift_hold (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_key   (shift_lvl),
    .o_held  (shift_held)
  );

  // one confirm event covers both entry gestures
  wire confirm = enter_press | shift_held;

  reg  [23:0] blink_cnt_reg;
  reg         blink_phase_reg;
  wire        blink_wrap = (blink_cnt_reg == BLINK_CYCLES[23:0] - 24'h000001);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blink_cnt_reg   <= 24'h000000;
      blink_phase_reg <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt_reg   <= 24'h000000;
      blink_phase_reg <= ~blink_phase_reg;
    end else begin
      blink_cnt_reg   <= blink_cnt_reg + 24'h000001;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // clamp to the top of the jog speed range
  function [`SPEED_W-1:0] clamp_speed;
    input [`SPEED_W-1:0] s;
    begin
      if (s > `JOG_SPEED_MAX) begin
        clamp_speed = `JOG_SPEED_MAX;
      end else begin
        clamp_speed = s;
      end
    end
  endfunction

  // key direction to motor direction
  function key_to_forward;
    input up;
    input swap;
    begin
      key_to_forward = up ^ swap;
    end
  endfunction

  // start gate shared by both utilities
  function start_allowed;
    input rdy;
    input ext;
    input forced;
    begin
      start_allowed = rdy & ~ext & ~forced;
    end
  endfunction

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  reg  [`MODE_W-1:0] state_reg;
  reg  [`MODE_W-1:0] state_next;
  reg  [`FUNC_W-1:0] func_reg;
  reg  [`FUNC_W-1:0] func_next;
  reg                servo_reg;
  reg                servo_next;
  reg                found_reg;
  reg                found_next;
  reg                refused_next;

  wire map_forced_on = (i_servo_enable_input_mapping == `MAP_FORCED_ON);
  // single key held: pressing both stops the motor
  wire one_dir       = up_lvl ^ down_lvl;

  always @* begin
    state_next   = state_reg;
    func_next    = func_reg;
    servo_next   = servo_reg;
    found_next   = found_reg;
    refused_next = o_start_refused;
    case (state_reg)
      ST_STATUS: begin
        if (set_press) begin
          state_next   = ST_SELECT;
          refused_next = 1'b0;
        end
      end
      ST_SELECT: begin
        if (up_press && func_reg != `FUNC_LAST) begin
          func_next = func_reg + 8'h01;
        end else if (down_press && func_reg != `FUNC_FIRST) begin
          func_next = func_reg - 8'h01;
        end
        if (set_press) begin
          state_next = ST_STATUS;
        end else if (confirm && func_reg == `FUNC_JOG) begin
          if (start_allowed(ready, ext_on, map_forced_on)) begin
            state_next   = ST_JOG;
            servo_next   = 1'b0;
            refused_next = 1'b0;
          end else begin
            refused_next = 1'b1;
          end
        end else if (confirm && func_reg == `FUNC_SEARCH) begin
          // relies on operator, still checked here
          if (start_allowed(ready, ext_on, map_forced_on)) begin
            state_next   = ST_SEARCH;
            servo_next   = 1'b0;
            found_next   = 1'b0;
            refused_next = 1'b0;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      ST_JOG: begin
        if (!ready) begin
          servo_next = 1'b0;
        end
        if (enter_press) begin
          state_next = ST_SELECT;
          servo_next = 1'b0;
        end else if (servo_reg) begin
          if (set_press || shift_held) begin
            servo_next = 1'b0;
          end
        end else if (shift_held) begin
          // hold exits when servo already off
          state_next = ST_SELECT;
        end else if (set_press && ready) begin
          servo_next = 1'b1;
        end
      end
      ST_SEARCH: begin
        // losing ready drops the search servo too
        if (!ready) begin
          servo_next = 1'b0;
        end
        if (confirm) begin
          state_next = ST_SELECT;
          servo_next = 1'b0;
          found_next = 1'b0;
        end else if ((svkey_press || set_press) && ready) begin
          servo_next = 1'b1;
        end
        if (servo_reg && !found_reg && one_dir && index_edge) begin
          found_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_STATUS;
        servo_next = 1'b0;
        found_next = 1'b0;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg       <= ST_STATUS;
      func_reg        <= `FUNC_FIRST;
      servo_reg       <= 1'b0;
      found_reg       <= 1'b0;
      o_start_refused <= 1'b0;
    end else begin
      state_reg       <= state_next;
      func_reg        <= func_next;
      servo_reg       <= servo_next;
      found_reg       <= found_next;
      o_start_refused <= refused_next;
    end
  end

  // ----------------------------------------
  // motion outputs
  // ----------------------------------------
  wire in_jog    = (state_reg == ST_JOG);
  wire in_search = (state_reg == ST_SEARCH);
  wire ot_ignore = in_jog | in_search;

  reg                run_next;
  reg                fwd_next;
  reg [`SPEED_W-1:0] speed_next;

  always @* begin
    run_next   = 1'b0;
    fwd_next   = o_dir_forward;
    speed_next = `SPEED_W'h0;
    if (in_jog && servo_reg && one_dir) begin
      run_next   = 1'b1;
      fwd_next   = key_to_forward(up_lvl, i_direction_select);
      speed_next = clamp_speed(i_jog_speed_setting);
    end else if (in_search && servo_reg && !found_reg && one_dir && !index_edge) begin
      run_next   = 1'b1;
      fwd_next   = key_to_forward(up_lvl, i_direction_select);
      speed_next = `SEARCH_SPEED;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_servo_enable    <= 1'b0;
      o_run             <= 1'b0;
      o_dir_forward     <= 1'b1;
      o_speed_ref       <= `SPEED_W'h0;
      o_hold_at_index   <= 1'b0;
      o_forward_stop    <= 1'b0;
      o_reverse_stop    <= 1'b0;
      o_display_mode    <= ST_STATUS;
      o_function_number <= `FUNC_FIRST;
      o_digit_blink     <= 1'b0;
      o_display_blink   <= 1'b0;
    end else begin
      o_servo_enable    <= servo_next;
      o_run             <= run_next & servo_next;
      // direction holds between moves so the last travel stays visible
      o_dir_forward     <= fwd_next;
      // speed zeroed with the servo, so a drop mid-move leaves no reference
      o_speed_ref       <= servo_next ? speed_next : `SPEED_W'h0;
      o_hold_at_index   <= in_search & found_next & servo_next;
      o_display_blink   <= in_search & found_next & blink_phase_reg;
      o_forward_stop    <= fot & ~ot_ignore;
      o_reverse_stop    <= rot & ~ot_ignore;
      o_display_mode    <= state_next;
      o_function_number <= func_next;
      o_digit_blink     <= (state_next == ST_SELECT) & blink_phase_reg;
    end
  end

endmodule

// *** design/jog_search_map.vh ***
// constants for the keypad jog and index search control
// Function
// - jog mode ignores both overtravel inhibit inputs
// - jog allowed only when servo ready
// - no jog start while external servo-on active
// - jog needs servo-on mapping other than forced-on
// - jog speed 0..10000 mm/s, default 50, live
// - enter press or shift hold enters jog
// - set key in jog enables servo
// - up forward, down reverse, stop on release
// - set or shift hold disables jog servo
// - leaving jog returns to jog utility selection
// - key direction follows direction select setting
// - index search ignores both overtravel inhibits
// - search runs to index pulse, then holds
// - search speed 60 mm/s at 5 m/s max
// - servo key or set key enables search servo
// - direction select 1 swaps search key directions
// - index found blinks display, servo-locked there
// - leaving search disables servo, shows selection
// - up/down step function number, digit blinks
// - set key switches status to utility selection
`ifndef JOG_SEARCH_MAP_VH
`define JOG_SEARCH_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_KHZ       25000
`define HOLD_TIME_MS       1000
`define BLINK_TIME_MS      250

// ----------------------------------------
// speeds in mm/s
// ----------------------------------------
`define SPEED_W            14
`define JOG_SPEED_MAX      14'h2710
`define JOG_SPEED_DEFAULT  14'h0032
`define SEARCH_SPEED       14'h003c
`define SEARCH_MAX_SPEED   14'h1388

// ----------------------------------------
// function numbers and mapping codes
// ----------------------------------------
`define FUNC_W             8
`define FUNC_FIRST         8'h00
`define FUNC_LAST          8'h14
`define FUNC_JOG           8'h02
`define FUNC_SEARCH        8'h03
`define MAP_W              4
`define MAP_FORCED_ON      4'h7
`define MAP_FORCED_OFF     4'h8

// ----------------------------------------
// display modes, one-hot
// ----------------------------------------
`define MODE_W             4
`define MODE_STATUS        4'h1
`define MODE_SELECT        4'h2
`define MODE_JOG           4'h4
`define MODE_SEARCH        4'h8

`endif

// *** design/key_hold_timer.v ***
// key hold timer: one pulse when a key has been held long enough
`timescale 1ns/1ns
`include "jog_search_map.vh"
module key_hold_timer #(
  parameter HOLD_CYCLES = `HOLD_TIME_MS * `CLK_FREQ_KHZ
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_key,
  output wire o_held
);

  reg  [24:0] count_reg;
  reg  [24:0] count_next;
  reg         done_reg;
  reg         done_next;
  reg         held_reg;
  reg         held_next;

  always @* begin
    count_next = count_reg;
    done_next  = done_reg;
    held_next  = 1'b0;
    if (!i_key) begin
      count_next = 25'h0000000;
      done_next  = 1'b0;
    end else if (!done_reg) begin
      if (count_reg == HOLD_CYCLES[24:0] - 25'h0000001) begin
        held_next = 1'b1;
        done_next = 1'b1;
      end else begin
        count_next = count_reg + 25'h0000001;
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= 25'h0000000;
      done_reg  <= 1'b0;
      held_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg  <= done_next;
      held_reg  <= held_next;
    end
  end

  assign o_held = held_reg;

endmodule

// *** verification/jog_search_ctrl_tb.sv ***
// self-checking bench for the jog and index search control
`timescale 1ns/1ns
`include "jog_search_map.vh"
module jog_search_ctrl_tb;
  localparam SET = 5, ENT = 4, SFT = 3, UP = 2, DN = 1, SV = 0;
  reg                 i_clk = 1'b0;
  reg                 i_rst_n = 1'b0;
  reg  [5:0]          k = 6'h0;
  reg  [1:0]          ovt = 2'h0;
  reg                 i_servo_ready = 1'b1;
  reg                 i_ext_servo_on = 1'b0;
  reg  [`MAP_W-1:0]   i_servo_enable_input_mapping = `MAP_FORCED_OFF;
  reg  [`SPEED_W-1:0] i_jog_speed_setting = `JOG_SPEED_DEFAULT;
  reg                 i_direction_select = 1'b0;
  reg  [31:0]         seed = 32'hc819;
  reg  [32:0]         q[$];
  reg  [32:0]         want;
  integer             failures = 0;
  integer             n_tests = 0;
  integer             i;
  event               ev;
  wire i_display_set_key = k[SET], i_enter_key = k[ENT], i_shift_key = k[SFT];
  wire i_up_key = k[UP], i_down_key = k[DN], i_servo_enable_key = k[SV];
  wire i_forward_overtravel_inhibit = ovt[1], i_reverse_overtravel_inhibit = ovt[0];
  wire i_index_pulse, o_servo_enable, o_run, o_dir_forward, o_hold_at_index, o_forward_stop, o_reverse_stop;
  wire o_digit_blink, o_display_blink, o_start_refused;
  wire [`SPEED_W-1:0] o_speed_ref;
  wire [`MODE_W-1:0]  o_display_mode;
  wire [`FUNC_W-1:0]  o_function_number;

  jog_search_ctrl #(.HOLD_CYCLES(20), .BLINK_CYCLES(4)) jog_search_ctrl_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_display_set_key(i_display_set_key), .i_enter_key(i_enter_key),
    .i_shift_key(i_shift_key), .i_up_key(i_up_key), .i_down_key(i_down_key),
    .i_servo_enable_key(i_servo_enable_key), .i_servo_ready(i_servo_ready), .i_ext_servo_on(i_ext_servo_on),
    .i_index_pulse(i_index_pulse), .i_forward_overtravel_inhibit(i_forward_overtravel_inhibit),
    .i_reverse_overtravel_inhibit(i_reverse_overtravel_inhibit),
    .i_servo_enable_input_mapping(i_servo_enable_input_mapping), .i_jog_speed_setting(i_jog_speed_setting),
    .i_direction_select(i_direction_select), .o_servo_enable(o_servo_enable), .o_run(o_run),
    .o_dir_forward(o_dir_forward), .o_speed_ref(o_speed_ref), .o_hold_at_index(o_hold_at_index),
    .o_forward_stop(o_forward_stop), .o_reverse_stop(o_reverse_stop), .o_display_mode(o_display_mode),
    .o_function_number(o_function_number), .o_digit_blink(o_digit_blink), .o_display_blink(o_display_blink),
    .o_start_refused(o_start_refused));
  motor_scale_model #(.INDEX_DELAY(12)) motor_scale_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_run(o_run),
    .o_index_pulse(i_index_pulse));

  always #20 i_clk = ~i_clk;

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // ----------------------------------------
  // drivers and scoreboard
  // ----------------------------------------
  task tick(input integer n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // overtravel inputs churn on every key change so masking is exercised
  task key(input integer b, input v);
    seed = xs(seed);
    ovt = seed[1:0];
    k[b] = v;
    tick(8);
  endtask
  task press(input integer b);
    key(b, 1'b1);
    key(b, 1'b0);
  endtask
  task hold_shift;
    key(SFT, 1'b1);
    tick(25);
    key(SFT, 1'b0);
  endtask
  task expect_now(input s, r, d, input [13:0] v, input h, input [3:0] m, input [7:0] f, input x);
    q.push_back({s, r, d, v, h, (m[2] | m[3]) ? 2'b00 : ovt, m, f, x});
    -> ev;
  endtask
  task check(input [32:0] seen, input [32:0] exp_v);
    n_tests = n_tests + 1;
    if (seen !== exp_v) begin
      failures = failures + 1;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, exp_v);
    end
  endtask
  task wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(ev) begin
    want = q.pop_front();
    check({o_servo_enable, o_run, o_dir_forward, o_speed_ref, o_hold_at_index, o_forward_stop, o_reverse_stop,
      o_display_mode, o_function_number, o_start_refused}, want);
  end

  initial begin
    tick(5000);
    failures = failures + 1;
    wrap_up;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    tick(8);
    i_rst_n = 1'b1;
    tick(1);
    expect_now(0, 0, 1, 0, 0, 1, 0, 0);
    press(SET);
    expect_now(0, 0, 1, 0, 0, 2, 0, 0);
    press(DN);
    expect_now(0, 0, 1, 0, 0, 2, 0, 0);
    press(UP);
    press(UP);
    expect_now(0, 0, 1, 0, 0, 2, 2, 0);
    for (i = 0; i < 3; i = i + 1) begin
      i_servo_enable_input_mapping = (i == 0) ? `MAP_FORCED_ON : `MAP_FORCED_OFF;
      i_ext_servo_on = (i == 1);
      i_servo_ready = (i != 2);
      press(ENT);
      expect_now(0, 0, 1, 0, 0, 2, 2, 1);
    end
    i_servo_enable_input_mapping = `MAP_FORCED_OFF;
    i_ext_servo_on = 1'b0;
    i_servo_ready = 1'b1;
    seed = xs(seed);
    i_jog_speed_setting = 14'(seed % 32'd10001);
    press(ENT);
    expect_now(0, 0, 1, 0, 0, 4, 2, 0);
    press(SET);
    expect_now(1, 0, 1, 0, 0, 4, 2, 0);
    key(DN, 1'b1);
    expect_now(1, 1, 0, i_jog_speed_setting, 0, 4, 2, 0);
    key(DN, 1'b0);
    expect_now(1, 0, 0, 0, 0, 4, 2, 0);
    key(UP, 1'b1);
    expect_now(1, 1, 1, i_jog_speed_setting, 0, 4, 2, 0);
    i_jog_speed_setting = 14'h3fff;
    tick(3);
    expect_now(1, 1, 1, `JOG_SPEED_MAX, 0, 4, 2, 0);
    // ready lost mid-move: servo drops and the set press is ignored
    i_servo_ready = 1'b0;
    press(SET);
    expect_now(0, 0, 1, 0, 0, 4, 2, 0);
    key(UP, 1'b0);
    i_servo_ready = 1'b1;
    press(SET);
    expect_now(1, 0, 1, 0, 0, 4, 2, 0);
    press(SET);
    expect_now(0, 0, 1, 0, 0, 4, 2, 0);
    press(SET);
    hold_shift;
    expect_now(0, 0, 1, 0, 0, 4, 2, 0);
    hold_shift;
    expect_now(0, 0, 1, 0, 0, 2, 2, 0);
    press(UP);
    i_direction_select = 1'b1;
    hold_shift;
    expect_now(0, 0, 1, 0, 0, 8, 3, 0);
    press(SV);
    expect_now(1, 0, 1, 0, 0, 8, 3, 0);
    key(UP, 1'b1);
    expect_now(1, 1, 0, `SEARCH_SPEED, 0, 8, 3, 0);
    tick(20);
    expect_now(1, 0, 0, 0, 1, 8, 3, 0);
    key(UP, 1'b0);
    press(ENT);
    expect_now(0, 0, 0, 0, 0, 2, 3, 0);
    tick(2);
    wrap_up;
  end
endmodule

// *** verification/jog_search_props.sv ***
// assertions and covers for the jog and index search control
`timescale 1ns/1ns
`include "jog_search_map.vh"
module jog_search_props #(
  parameter BLINK_CYCLES = 4
) (
  input wire                i_clk,
  input wire                i_rst_n,
  input wire                i_servo_ready,
  input wire [`SPEED_W-1:0] i_jog_speed_setting,
  input wire                o_servo_enable,
  input wire                o_run,
  input wire [`SPEED_W-1:0] o_speed_ref,
  input wire                o_hold_at_index,
  input wire                o_forward_stop,
  input wire                o_reverse_stop,
  input wire [`MODE_W-1:0]  o_display_mode,
  input wire                o_digit_blink,
  input wire                o_display_blink,
  input wire                o_start_refused
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // blink watchdogs
  // ----------------------------------------
  // a blink that freezes is caught by cycles since its last toggle
  reg  [31:0]         dig_cnt_reg;
  reg  [31:0]         dsp_cnt_reg;
  wire [`SPEED_W-1:0] jog_clamp = (i_jog_speed_setting > `JOG_SPEED_MAX) ? `JOG_SPEED_MAX : i_jog_speed_setting;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dig_cnt_reg <= 32'h0;
      dsp_cnt_reg <= 32'h0;
    end else begin
      dig_cnt_reg <= (o_display_mode != `MODE_SELECT || $changed(o_digit_blink)) ? 32'h0 : dig_cnt_reg + 32'h1;
      dsp_cnt_reg <= (!o_hold_at_index || $changed(o_display_blink)) ? 32'h0 : dsp_cnt_reg + 32'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_stops_masked: assert property ((o_display_mode[2] | o_display_mode[3]) && $stable(o_display_mode) |->
    !(o_forward_stop | o_reverse_stop)) else $error("inhibit passed in jog or search");
  a_idle_speed_zero: assert property (!o_run |-> o_speed_ref == 14'h0)
    else $error("speed without run");
  a_run_needs_servo: assert property (o_run |-> o_servo_enable)
    else $error("run without servo");
  a_search_speed: assert property (o_run && o_display_mode == `MODE_SEARCH |-> o_speed_ref == `SEARCH_SPEED)
    else $error("search speed wrong");
  a_jog_speed_live: assert property (o_run && o_display_mode == `MODE_JOG && $stable(i_jog_speed_setting)
    |-> o_speed_ref == jog_clamp) else $error("jog speed wrong");
  a_hold_locked: assert property (o_hold_at_index |-> o_servo_enable && !o_run
    && o_display_mode == `MODE_SEARCH) else $error("index hold without lock");
  a_refuse_stays: assert property ($rose(o_start_refused) |-> o_display_mode == `MODE_SELECT)
    else $error("refused start left select");
  a_ready_drop: assert property ($fell(i_servo_ready) |-> ##[1:4] !o_servo_enable)
    else $error("servo kept after ready loss");
  a_digit_blinks: assert property (dig_cnt_reg <= BLINK_CYCLES + 2)
    else $error("digit blink stuck");
  a_index_blinks: assert property (dsp_cnt_reg <= BLINK_CYCLES + 2)
    else $error("display blink stuck");
  a_servo_off_idle: assert property (!(o_display_mode[2] | o_display_mode[3]) && $stable(o_display_mode)
    |-> !o_servo_enable) else $error("servo on outside jog or search");
  c_jog_run: cover property (o_run && o_display_mode == `MODE_JOG);
  c_index_hold: cover property (o_hold_at_index && o_display_blink);
  c_refused: cover property ($rose(o_start_refused));
endmodule

bind jog_search_ctrl jog_search_props #(.BLINK_CYCLES(BLINK_CYCLES)) jog_search_props_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_servo_ready(i_servo_ready), .i_jog_speed_setting(i_jog_speed_setting),
  .o_servo_enable(o_servo_enable), .o_run(o_run), .o_speed_ref(o_speed_ref), .o_hold_at_index(o_hold_at_index),
  .o_forward_stop(o_forward_stop), .o_reverse_stop(o_reverse_stop), .o_display_mode(o_display_mode),
  .o_digit_blink(o_digit_blink), .o_display_blink(o_display_blink), .o_start_refused(o_start_refused));

// *** verification/motor_scale_model.sv ***
// behavioural linear motor whose scale index mark passes after a fixed travel
`timescale 1ns/1ns
module motor_scale_model #(
  parameter INDEX_DELAY = 12
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_run,
  output reg  o_index_pulse
);
  reg [31:0] travel_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      travel_reg <= 32'h0;
      o_index_pulse <= 1'b0;
    end else begin
      travel_reg <= i_run ? travel_reg + 32'h1 : 32'h0;
      o_index_pulse <= i_run && (travel_reg == INDEX_DELAY);
    end
  end
endmodule
